// >>> pkg/clock_gen_pkg.sv
// constants and types for the clock generator configuration block
`default_nettype none
package clock_gen_pkg;
   // ==========================================
   // timing
   localparam int SYS_CLOCK_HZ = 40_000_000;
   localparam int SCM_TARGET_HZ = 8_000_000;
   localparam logic [7:0] SCM_PERIOD = 8'(SYS_CLOCK_HZ / SCM_TARGET_HZ);
   localparam int IRG_NOMINAL_HZ = 243_000;
   localparam int IRG_CYCLES = (SYS_CLOCK_HZ + IRG_NOMINAL_HZ / 2) / IRG_NOMINAL_HZ;
   localparam logic [7:0] TRIM_RESET = 8'h80;
   localparam int TRIM_SHIFT = 2;
   localparam logic [8:0] IRG_PERIOD_BASE = 9'(IRG_CYCLES - (TRIM_RESET >> TRIM_SHIFT));
   localparam logic [2:0] IRG_PRESCALE_LAST = 3'h6;
   localparam int LOSS_TIME_US = 100;
   localparam int LOSS_CYCLES = LOSS_TIME_US * (SYS_CLOCK_HZ / 1_000_000);
   localparam logic [11:0] LOSS_LAST = 12'(LOSS_CYCLES - 1);
   localparam int LOCK_TOL_SHIFT = 3;
   localparam logic [6:0] P_LOW_RANGE = 7'h40;
   localparam logic [6:0] P_HIGH_RANGE = 7'h01;
   localparam logic [6:0] P_INTERNAL = 7'h40;
   localparam logic [4:0] MULT_BASE = 5'h04;
   // ==========================================
   // register map
   localparam logic [2:0] OFS_CONTROL_ONE = 3'h0;
   localparam logic [2:0] OFS_CONTROL_TWO = 3'h1;
   localparam logic [2:0] OFS_STATUS_ONE = 3'h2;
   localparam logic [2:0] OFS_STATUS_TWO = 3'h3;
   localparam logic [2:0] OFS_TRIM = 3'h4;
   localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
   localparam logic [7:0] CONTROL_ONE_MASK = 8'hfe;
   localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
   localparam int GAIN_BIT = 7;
   localparam int RANGE_BIT = 6;
   localparam int REF_SEL_BIT = 5;
   localparam int MODE_HI = 4;
   localparam int MODE_LO = 3;
   localparam int STOP_KEEP_BIT = 2;
   localparam int LOSS_DET_DIS_BIT = 1;
   localparam int LOCK_RST_BIT = 7;
   localparam int MULT_HI = 6;
   localparam int MULT_LO = 4;
   localparam int CLOCK_RST_BIT = 3;
   localparam int DIV_HI = 2;
   localparam int DIV_LO = 0;
   localparam int IRQ_FLAG_BIT = 0;
   localparam logic [1:0] MODE_SCM = 2'h0;
   localparam logic [1:0] MODE_FEI = 2'h1;
   localparam logic [1:0] MODE_FBE = 2'h2;
   localparam logic [1:0] MODE_FEE = 2'h3;
   // ==========================================
   // types
   typedef enum logic [1:0] {loop_open, loop_acquire, loop_locked} loop_state_t;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
   } bus_req_t;
   typedef struct packed {
      logic enable;
      logic high_gain;
      logic high_range;
   } osc_ctrl_t;
   function automatic logic [4:0] mult_decode(input logic [2:0] code);
      return MULT_BASE + 5'({code, 1'b0});
   endfunction
endpackage
`default_nettype wire

// >>> rtl/clock_generator.sv
// clock generator: control registers, mode select, loop and loss detection
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module clock_generator (
   input wire logic clock,
   input wire logic reset_n,
   input wire clock_gen_pkg::bus_req_t bus,
   output logic [7:0] read_data,
   input wire logic external_reference,
   input wire logic stop_mode,
   output clock_gen_pkg::osc_ctrl_t oscillator,
   output logic internal_reference_enable,
   output logic generator_output_tick,
   output logic bus_clock_tick,
   output logic interrupt_request,
   output logic reset_request
);
   // ==========================================
   // registers
   logic [7:0] clock_gen_control_one;
   logic [7:0] clock_gen_control_two;
   logic [7:0] internal_reference_trim;
   logic [7:0] clock_gen_status_one;
   logic [7:0] clock_gen_status_two;
   logic [7:0] next_read_data;
   logic [1:0] clock_mode_field;
   logic [2:0] multiplier_field;
   logic [2:0] output_divider_field;
   logic engaged;
   logic external_watch;
   logic irq_flag;
   logic lock_loss_flag;
   logic clock_loss_flag;
   logic oscillator_stable_flag;

   assign clock_mode_field = clock_gen_control_one[clock_gen_pkg::MODE_HI:clock_gen_pkg::MODE_LO];
   assign multiplier_field = clock_gen_control_two[clock_gen_pkg::MULT_HI:clock_gen_pkg::MULT_LO];
   assign output_divider_field = clock_gen_control_two[clock_gen_pkg::DIV_HI:clock_gen_pkg::DIV_LO];
   assign engaged = clock_mode_field == clock_gen_pkg::MODE_FEE ||
      clock_mode_field == clock_gen_pkg::MODE_FEI;
   // upper mode bit means external reference
   assign external_watch = clock_gen_control_one[clock_gen_pkg::MODE_HI];

   // reset values select self-clocked mode, R of one
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         clock_gen_control_one <= clock_gen_pkg::CONTROL_ONE_RESET;
         clock_gen_control_two <= clock_gen_pkg::CONTROL_TWO_RESET;
         internal_reference_trim <= clock_gen_pkg::TRIM_RESET;
      end else if (bus.write) begin
         case (bus.addr)
            clock_gen_pkg::OFS_CONTROL_ONE: begin
               clock_gen_control_one <= bus.wdata & clock_gen_pkg::CONTROL_ONE_MASK;
            end
            clock_gen_pkg::OFS_CONTROL_TWO: begin
               clock_gen_control_two <= bus.wdata;
            end
            clock_gen_pkg::OFS_TRIM: begin
               internal_reference_trim <= bus.wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // read path
   always_comb begin
      next_read_data = '0;
      if (bus.read) begin
         case (bus.addr)
            clock_gen_pkg::OFS_CONTROL_ONE: next_read_data = clock_gen_control_one;
            clock_gen_pkg::OFS_CONTROL_TWO: next_read_data = clock_gen_control_two;
            clock_gen_pkg::OFS_STATUS_ONE: next_read_data = clock_gen_status_one;
            clock_gen_pkg::OFS_STATUS_TWO: next_read_data = clock_gen_status_two;
            clock_gen_pkg::OFS_TRIM: next_read_data = internal_reference_trim;
            default: next_read_data = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         read_data <= '0;
      end else begin
         read_data <= next_read_data;
      end
   end

   // ==========================================
   // reference pin and internal reference
   logic ref_meta;
   logic ref_sync;
   logic ref_prev;
   logic ref_edge;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_prev <= 1'b0;
      end else begin
         ref_meta <= external_reference;
         ref_sync <= ref_meta;
         ref_prev <= ref_sync;
      end
   end
   assign ref_edge = ref_sync && !ref_prev;

   logic [8:0] irg_period;
   logic [8:0] irg_count;
   logic [2:0] irg_prescale;
   logic irg_tick;
   logic fei_ref_tick;

   // trim spans about plus or minus 19 percent of nominal
   assign irg_period = clock_gen_pkg::IRG_PERIOD_BASE +
      9'(internal_reference_trim >> clock_gen_pkg::TRIM_SHIFT);
   assign irg_tick = internal_reference_enable && irg_count >= irg_period - 9'h001;
   // internal reference divided by seven feeds the loop
   assign fei_ref_tick = irg_tick && irg_prescale == clock_gen_pkg::IRG_PRESCALE_LAST;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irg_count <= '0;
         irg_prescale <= '0;
      end else if (!internal_reference_enable) begin
         irg_count <= '0;
         irg_prescale <= '0;
      end else if (irg_tick) begin
         irg_count <= '0;
         irg_prescale <= fei_ref_tick ? 3'h0 : irg_prescale + 3'h1;
      end else begin
         irg_count <= irg_count + 9'h001;
      end
   end

   // ==========================================
   // controlled oscillator and frequency-locked loop
   logic [7:0] dco_period;
   logic [7:0] dco_count;
   logic dco_tick;
   logic loop_ref_tick;
   logic [6:0] loop_prescale;
   logic [11:0] loop_target;
   logic [11:0] window_count;
   logic [11:0] loop_error;
   logic within_lock;
   logic lock_loss_event;
   clock_gen_pkg::loop_state_t loop_state;

   assign dco_tick = dco_count >= dco_period - 8'h01;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dco_count <= '0;
      end else if (dco_tick) begin
         dco_count <= '0;
      end else begin
         dco_count <= dco_count + 8'h01;
      end
   end

   always_comb begin
      if (clock_mode_field == clock_gen_pkg::MODE_FEI) begin
         loop_prescale = clock_gen_pkg::P_INTERNAL;
      end else if (clock_gen_control_one[clock_gen_pkg::RANGE_BIT]) begin
         loop_prescale = clock_gen_pkg::P_HIGH_RANGE;
      end else begin
         loop_prescale = clock_gen_pkg::P_LOW_RANGE;
      end
   end

   assign loop_target = 12'(loop_prescale * clock_gen_pkg::mult_decode(multiplier_field));
   assign loop_ref_tick = clock_mode_field == clock_gen_pkg::MODE_FEI ? fei_ref_tick :
      ref_edge;
   assign loop_error = window_count > loop_target ? window_count - loop_target :
      loop_target - window_count;
   assign within_lock = loop_error <= (loop_target >> clock_gen_pkg::LOCK_TOL_SHIFT);
   assign lock_loss_event = loop_state == clock_gen_pkg::loop_locked && loop_ref_tick &&
      !within_lock && engaged;

   // oscillator ticks per reference period are steered to P times N
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         loop_state <= clock_gen_pkg::loop_open;
      end else if (!engaged) begin
         loop_state <= clock_gen_pkg::loop_open;
      end else if (loop_ref_tick) begin
         case (loop_state)
            clock_gen_pkg::loop_open: loop_state <= clock_gen_pkg::loop_acquire;
            clock_gen_pkg::loop_acquire: begin
               if (within_lock) begin
                  loop_state <= clock_gen_pkg::loop_locked;
               end
            end
            clock_gen_pkg::loop_locked: begin
               if (!within_lock) begin
                  loop_state <= clock_gen_pkg::loop_acquire;
               end
            end
            default: loop_state <= clock_gen_pkg::loop_open;
         endcase
      end
   end

   // first window after engaging is partial, so it only starts the count
   // a tick on the reference edge opens the new window, else windows lose one
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         window_count <= '0;
      end else if (!engaged) begin
         window_count <= '0;
      end else if (loop_ref_tick) begin
         window_count <= dco_tick ? 12'h001 : 12'h000;
      end else if (dco_tick && window_count != '1) begin
         window_count <= window_count + 12'h001;
      end
   end

   // outside the loop the oscillator returns to its free-run rate
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dco_period <= clock_gen_pkg::SCM_PERIOD;
      end else if (!engaged) begin
         dco_period <= clock_gen_pkg::SCM_PERIOD;
      end else if (loop_ref_tick && loop_state != clock_gen_pkg::loop_open && !within_lock) begin
         if (window_count < loop_target && dco_period != 8'h01) begin
            dco_period <= dco_period - 8'h01;
         end else if (window_count > loop_target && dco_period != '1) begin
            dco_period <= dco_period + 8'h01;
         end
      end
   end

   // ==========================================
   // output divider and bus clock
   logic [6:0] div_count;
   logic [6:0] div_limit;
   logic source_tick;
   logic bus_phase;
   logic next_generator_tick;

   // R is a power of two from the divider field
   assign div_limit = 7'((8'h01 << output_divider_field) - 8'h01);
   // bypass mode divides the reference, others the oscillator
   assign source_tick = clock_mode_field == clock_gen_pkg::MODE_FBE ? ref_edge : dco_tick;
   assign next_generator_tick = source_tick && div_count >= div_limit;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div_count <= '0;
      end else if (next_generator_tick) begin
         div_count <= '0;
      end else if (source_tick) begin
         div_count <= div_count + 7'h01;
      end
   end

   // bus runs at half the generator output
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         generator_output_tick <= 1'b0;
         bus_clock_tick <= 1'b0;
         bus_phase <= 1'b0;
      end else begin
         generator_output_tick <= next_generator_tick;
         bus_clock_tick <= next_generator_tick && bus_phase;
         if (next_generator_tick) begin
            bus_phase <= !bus_phase;
         end
      end
   end

   // ==========================================
   // loss of reference clock
   logic [11:0] loss_count;
   logic ref_lost;
   logic clock_loss_event;

   assign clock_loss_event = external_watch && !ref_lost && !ref_edge &&
      !clock_gen_control_one[clock_gen_pkg::LOSS_DET_DIS_BIT] &&
      loss_count == clock_gen_pkg::LOSS_LAST;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         loss_count <= '0;
         ref_lost <= 1'b0;
      end else if (!external_watch || ref_edge) begin
         loss_count <= '0;
         ref_lost <= 1'b0;
      end else if (clock_loss_event) begin
         ref_lost <= 1'b1;
      end else if (loss_count != clock_gen_pkg::LOSS_LAST) begin
         loss_count <= loss_count + 12'h001;
      end
   end

   // ==========================================
   // status, interrupt and reset request
   logic clear_write;

   // only a one written to the flag bit has any effect
   assign clear_write = bus.write && bus.addr == clock_gen_pkg::OFS_STATUS_ONE &&
      bus.wdata[clock_gen_pkg::IRQ_FLAG_BIT];

   // lock loss raises the flag unless reset is chosen
   // clock loss likewise; a new event beats a same-cycle clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lock_loss_flag <= 1'b0;
         clock_loss_flag <= 1'b0;
         irq_flag <= 1'b0;
         reset_request <= 1'b0;
      end else begin
         reset_request <=
            (lock_loss_event && clock_gen_control_two[clock_gen_pkg::LOCK_RST_BIT]) ||
            (clock_loss_event && clock_gen_control_two[clock_gen_pkg::CLOCK_RST_BIT]);
         if (lock_loss_event && !clock_gen_control_two[clock_gen_pkg::LOCK_RST_BIT]) begin
            lock_loss_flag <= 1'b1;
         end else if (clear_write) begin
            lock_loss_flag <= 1'b0;
         end
         if (clock_loss_event && !clock_gen_control_two[clock_gen_pkg::CLOCK_RST_BIT]) begin
            clock_loss_flag <= 1'b1;
         end else if (clear_write) begin
            clock_loss_flag <= 1'b0;
         end
         if ((lock_loss_event && !clock_gen_control_two[clock_gen_pkg::LOCK_RST_BIT]) ||
            (clock_loss_event && !clock_gen_control_two[clock_gen_pkg::CLOCK_RST_BIT])) begin
            irq_flag <= 1'b1;
         end else if (clear_write) begin
            irq_flag <= 1'b0;
         end
      end
   end
   assign interrupt_request = irq_flag;

   // free-running modes count as stable at once
   assign oscillator_stable_flag = !engaged || loop_state == clock_gen_pkg::loop_locked;
   assign clock_gen_status_one = {clock_mode_field, 1'b0, !ref_lost,
      loop_state == clock_gen_pkg::loop_locked, lock_loss_flag, clock_loss_flag, irq_flag};
   assign clock_gen_status_two = {7'h00, oscillator_stable_flag};

   // ==========================================
   // oscillator pin controls
   // gain bit passed straight to the oscillator
   // crystal requested only in external modes
   // stop mode halts it unless stop-keep is set
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         oscillator <= '0;
         internal_reference_enable <= 1'b0;
      end else begin
         oscillator.enable <= clock_gen_control_one[clock_gen_pkg::REF_SEL_BIT] &&
            external_watch &&
            (!stop_mode || clock_gen_control_one[clock_gen_pkg::STOP_KEEP_BIT]);
         oscillator.high_gain <= clock_gen_control_one[clock_gen_pkg::GAIN_BIT];
         oscillator.high_range <= clock_gen_control_one[clock_gen_pkg::RANGE_BIT];
         internal_reference_enable <= clock_mode_field == clock_gen_pkg::MODE_FEI;
      end
   end

   // ==========================================
   // checks
   a_reset_self_clocked: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(reset_n) |-> clock_mode_field == clock_gen_pkg::MODE_SCM &&
      dco_period == clock_gen_pkg::SCM_PERIOD && output_divider_field == '0)
      else $error("not self-clocked after reset");
   a_bus_half_rate: assert property (@(posedge clock) disable iff (!reset_n)
      bus_clock_tick |-> generator_output_tick && !bus_phase)
      else $error("bus tick without generator tick");
   a_lock_on_target: assert property (@(posedge clock) disable iff (!reset_n)
      loop_state == clock_gen_pkg::loop_acquire && loop_ref_tick && engaged && within_lock
      |=> loop_state == clock_gen_pkg::loop_locked)
      else $error("loop did not lock on target");
   a_range_prescale: assert property (@(posedge clock) disable iff (!reset_n)
      clock_mode_field == clock_gen_pkg::MODE_FEE |-> loop_target ==
      12'((clock_gen_control_one[clock_gen_pkg::RANGE_BIT] ? 7'h01 : 7'h40) *
      clock_gen_pkg::mult_decode(multiplier_field)))
      else $error("wrong loop target for range");
   a_gain_follows: assert property (@(posedge clock) disable iff (!reset_n)
      !clock_gen_control_one[clock_gen_pkg::GAIN_BIT] |=> !oscillator.high_gain)
      else $error("oscillator not low power");
   a_osc_internal_off: assert property (@(posedge clock) disable iff (!reset_n)
      !external_watch |=> !oscillator.enable)
      else $error("oscillator requested in internal mode");
   a_bit0_zero: assert property (@(posedge clock) disable iff (!reset_n)
      bus.read && bus.addr == clock_gen_pkg::OFS_CONTROL_ONE |=> !read_data[0])
      else $error("control one bit 0 read as one");
   a_lock_loss_irq: assert property (@(posedge clock) disable iff (!reset_n)
      lock_loss_event && !clock_gen_control_two[clock_gen_pkg::LOCK_RST_BIT]
      |=> interrupt_request && !reset_request)
      else $error("lock loss did not interrupt");
   a_clock_loss_irq: assert property (@(posedge clock) disable iff (!reset_n)
      clock_loss_event && !clock_gen_control_two[clock_gen_pkg::CLOCK_RST_BIT]
      |=> interrupt_request && clock_loss_flag && !reset_request)
      else $error("clock loss did not interrupt");
   a_div_by_one: assert property (@(posedge clock) disable iff (!reset_n)
      output_divider_field == '0 && source_tick |=> generator_output_tick)
      else $error("divide by one skipped a tick");
endmodule
`default_nettype wire

// >>> testbench/ref_source.sv
// behavioural external reference oscillator facing the clock generator
`timescale 1ns/1ps
`default_nettype none
module ref_source (
   input wire logic run,
   input wire logic [15:0] half_ns,
   output logic external_reference
);
   // ==========================================
   // oscillator
   initial external_reference = 1'b0;
   // a stopped crystal stands low, never holding a stale level
   always begin
      if (run) begin
         #(half_ns) external_reference = ~external_reference;
      end else begin
         external_reference = 1'b0;
         @(run);
         // keeps pin edges off the sampling clock edges
         #5;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the clock generator configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ==========================================
   // signals and instances
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic stop_mode = 1'b0;
   logic run = 1'b0;
   logic [15:0] half_ns = 16'h012c;
   clock_gen_pkg::bus_req_t bus = '0;
   clock_gen_pkg::osc_ctrl_t osc;
   logic [7:0] read_data;
   logic ext_ref, irg_en, gen_tick, bus_tick, irq, rst_req;
   logic rd_d = 1'b0;
   logic [15:0] notes[$];
   logic [15:0] note;
   logic [31:0] seed = 32'he41d064e;
   int failures = 0, n_checks = 0, resets = 0, cg, cb;
   always #12.5 clock = ~clock;
   clock_generator clock_generator_inst (.clock(clock), .reset_n(reset_n), .bus(bus),
      .read_data(read_data), .external_reference(ext_ref), .stop_mode(stop_mode),
      .oscillator(osc), .internal_reference_enable(irg_en), .generator_output_tick(gen_tick),
      .bus_clock_tick(bus_tick), .interrupt_request(irq), .reset_request(rst_req));
   ref_source ref_source_inst (.run(run), .half_ns(half_ns), .external_reference(ext_ref));
   // ==========================================
   // helpers
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // two idle edges let registered outputs settle before sampling
   task automatic op(logic [2:0] a, logic [7:0] d, logic w);
      bus <= {a, d, w, ~w};
      @(posedge clock);
      bus <= '0;
      repeat (2) @(posedge clock);
   endtask
   task automatic rd(logic [2:0] a, logic [7:0] m, logic [7:0] e);
      notes.push_back({m, e});
      op(a, 8'h00, 1'b0);
   endtask
   task automatic count(int n);
      cg = 0;
      cb = 0;
      repeat (n) begin
         @(posedge clock);
         cg += (gen_tick === 1'b1);
         cb += (bus_tick === 1'b1);
      end
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // read monitor: read data stands only in the cycle after the strobe
   always @(posedge clock) begin
      if (rd_d) begin
         note = notes.pop_front();
         check(read_data & note[15:8], note[7:0]);
      end
      rd_d <= bus.read;
      if (rst_req === 1'b1) resets++;
   end
   initial begin
      #(25 * 20000);
      failures++;
      summarize();
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      rd(3'h0, 8'hff, 8'h00);
      rd(3'h1, 8'hff, 8'h00);
      rd(3'h4, 8'hff, clock_gen_pkg::TRIM_RESET);
      rd(3'h5, 8'hff, 8'h00);
      op(3'h0, 8'h01, 1'b1);
      rd(3'h0, 8'hff, 8'h00);
      repeat (4) begin
         seed = lfsr(seed);
         op(3'h1, seed[7:0], 1'b1);
         rd(3'h1, 8'hff, seed[7:0]);
      end
      op(3'h1, 8'h00, 1'b1);
      count(20);
      count(100);
      check(8'(cg), 8'h14);
      check(8'(cb), 8'h0a);
      op(3'h1, 8'h01, 1'b1);
      count(20);
      count(100);
      check(8'(cg), 8'h0a);
      check(8'(cb), 8'h05);
      op(3'h0, 8'hf0, 1'b1);
      check(8'(osc), 8'h07);
      stop_mode <= 1'b1;
      repeat (2) @(posedge clock);
      check(8'(osc), 8'h03);
      op(3'h0, 8'hf4, 1'b1);
      check(8'(osc), 8'h07);
      stop_mode <= 1'b0;
      op(3'h0, 8'h28, 1'b1);
      check(8'(irg_en), 8'h01);
      // trim with R doubled, then restore R
      op(3'h1, 8'h02, 1'b1);
      seed = lfsr(seed);
      op(3'h4, seed[7:0], 1'b1);
      rd(3'h4, 8'hff, seed[7:0]);
      op(3'h1, 8'h01, 1'b1);
      rd(3'h1, 8'hff, 8'h01);
      run <= 1'b1;
      op(3'h0, 8'h30, 1'b1);
      check(8'(osc), 8'h04);
      count(48);
      count(480);
      check(8'(cg > 8 && cg < 12), 8'h01);
      op(3'h2, 8'h01, 1'b1);
      run <= 1'b0;
      count(4100);
      check(8'(irq), 8'h01);
      rd(3'h2, 8'hc3, 8'h83);
      op(3'h2, 8'hfe, 1'b1);
      rd(3'h2, 8'h03, 8'h03);
      run <= 1'b1;
      count(40);
      op(3'h2, 8'h01, 1'b1);
      rd(3'h2, 8'h07, 8'h00);
      check(8'(irq), 8'h00);
      op(3'h1, 8'h00, 1'b1);
      op(3'h0, 8'h78, 1'b1);
      count(3000);
      op(3'h2, 8'h01, 1'b1);
      // stable flag confirmed before the timed measurement
      rd(3'h3, 8'h01, 8'h01);
      rd(3'h2, 8'h0f, 8'h08);
      count(24);
      count(240);
      check(8'(cg > 38 && cg < 42), 8'h01);
      check(8'(irg_en), 8'h00);
      half_ns <= 16'h01f4;
      count(200);
      check(8'(irq), 8'h01);
      rd(3'h2, 8'h07, 8'h05);
      // detect disabled: a stopped reference raises nothing
      run <= 1'b0;
      op(3'h0, 8'h7a, 1'b1);
      count(40);
      op(3'h2, 8'h01, 1'b1);
      count(4100);
      rd(3'h2, 8'h07, 8'h00);
      check(8'(resets), 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
